// ---- verilog/wdw_top.sv ----
`timescale 1ns/10ps
// Behaviour
// - In sleep or idle, wake on external reset, port A fall, interrupt or overflow.
// - External reset wake gives full reset; overflow wake gives watchdog reset.
// - Power-down flag cleared at power-up and clear-watchdog; set by halt.
// - Time-out sets its flag; wake by it resets only program counter and stack.
// - Enabled port A pin falling edge wakes; execution resumes after halt.
// - Wake by disabled interrupt or full stack resumes after halt, stays pending.
// - Wake by enabled interrupt with stack room takes normal interrupt response.
// - Interrupt already requesting when halt executes cannot wake the device.
// - Counter runs on slow oscillator, select 000 is 2^8 up to 2^15, default 011.
// - Key 10101 disables, 01010 enables, anything else requests reset.
// - Invalid key resets within 1 to 2 slow cycles and sets key reset flag.
// - Only a key reset sets the key reset flag; software may clear only.
// - Idle clock bit 1 keeps system clock in idle, 0 stops it.
// - Low-voltage flag reads 1 after that reset; software may clear only.
// - Counter cleared by key reset, external reset, clear-watchdog and halt.
// - Time-out in normal run resets the device and sets the time-out flag.
module wdw_top
  import wdw_pkg::*;
#(
  parameter int PORT_W = 8
)
(
  input  wire logic              clock_i,
  input  wire logic              arst_n_i,
  input  wire logic              ext_reset_i,
  input  wire logic              lvr_event_i,
  input  wire logic              slow_osc_i,
  input  wire logic [PORT_W-1:0] port_a_i,
  input  wire logic              halt_i,
  input  wire logic              idle_mode_i,
  input  wire logic              clear_watchdog_instruction_i,
  input  wire logic              irq_req_i,
  input  wire logic              irq_enabled_i,
  input  wire logic              stack_full_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   system_reset_o,
  output logic                   pc_sp_reset_o,
  output logic                   wake_resume_o,
  output logic                   wake_irq_service_o,
  output logic                   sysclk_run_o,
  output logic                   power_down_flag_o,
  output logic                   timeout_flag_o,
  output logic                   irq_o
);

  logic [1:0]        slow_sync_r;
  logic              slow_d_r;
  logic [1:0]        ext_sync_r;
  logic [PORT_W-1:0] pa_s1_r;
  logic [PORT_W-1:0] pa_s2_r;
  logic [PORT_W-1:0] pa_d_r;

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      slow_sync_r <= 2'h0;
      slow_d_r    <= 1'b0;
      ext_sync_r  <= 2'h0;
      pa_s1_r     <= '1;
      pa_s2_r     <= '1;
      pa_d_r      <= '1;
    end
    else
    begin
      slow_sync_r <= {slow_sync_r[0], slow_osc_i};
      slow_d_r    <= slow_sync_r[1];
      ext_sync_r  <= {ext_sync_r[0], ext_reset_i};
      pa_s1_r     <= port_a_i;
      pa_s2_r     <= pa_s1_r;
      pa_d_r      <= pa_s2_r;
    end
  end

  logic              slow_tick;
  logic              ext_rst;
  logic [PORT_W-1:0] pa_fall;
  assign slow_tick = slow_sync_r[1] & ~slow_d_r;
  assign ext_rst   = ext_sync_r[1];
  assign pa_fall   = pa_d_r & ~pa_s2_r;

  function automatic logic [WDW_CNT_W-1:0] limit_of(input logic [2:0] sel);
    limit_of = WDW_CNT_W'(1) << (WDW_BASE_EXP + int'(sel));
  endfunction

  logic [7:0]            wdt_ctrl_r,  wdt_ctrl_nxt;
  logic                  sysclk_r,    sysclk_nxt;
  logic                  lvr_f_r,     lvr_f_nxt;
  logic                  key_f_r,     key_f_nxt;
  logic [PORT_W-1:0]     wake_en_r,   wake_en_nxt;
  logic [WDW_EV_W-1:0]   ev_st_r,     ev_st_nxt;
  logic [WDW_EV_W-1:0]   ev_en_r,     ev_en_nxt;
  logic [WDW_CNT_W-1:0]  cnt_r,       cnt_nxt;
  logic [1:0]            kdly_r,      kdly_nxt;
  logic                  kpend_r,     kpend_nxt;
  wdw_pwr_e              pwr_r,       pwr_nxt;
  logic                  irq_block_r, irq_block_nxt;
  logic                  pdf_r,       pdf_nxt;
  logic                  to_r,        to_nxt;
  logic                  ack_r,       ack_nxt;
  logic [31:0]           dat_r,       dat_nxt;
  logic                  sysrst_r,    sysrst_nxt;
  logic                  pcsp_r,      pcsp_nxt;
  logic                  resume_r,    resume_nxt;
  logic                  svc_r,       svc_nxt;
  logic                  sclk_r,      sclk_nxt;
  logic                  irq_r,       irq_nxt;

  logic [4:0] key;
  logic       wdt_on;
  logic       key_bad;
  logic       overflow;
  logic       asleep;
  logic       wr;
  logic       key_fire;
  logic       wake_pin;
  logic       wake_irq;
  logic [WDW_EV_W-1:0] ev_set;

  assign key      = wdt_ctrl_r[WDW_KEY_MSB:WDW_KEY_LSB];
  assign wdt_on   = (key != WDW_KEY_DISABLE);
  assign key_bad  = (key != WDW_KEY_DISABLE) && (key != WDW_KEY_ENABLE);
  assign overflow = wdt_on && slow_tick
                 && (cnt_r + 1'b1 >= limit_of(wdt_ctrl_r[WDW_PER_MSB:0]));
  assign asleep   = (pwr_r != WDW_RUN);
  // Writes land on the edge at which the master samples ack, not before
  assign wr       = wb_cyc_i && wb_stb_i && wb_we_i && ack_r && wb_sel_i[0];
  assign key_fire = kpend_r && slow_tick && (kdly_r == 2'h0);
  assign wake_pin = asleep && |(pa_fall & wake_en_r);
  assign wake_irq = asleep && irq_req_i && !irq_block_r;

  always_comb
  begin
    wdt_ctrl_nxt  = wdt_ctrl_r;
    sysclk_nxt    = sysclk_r;
    lvr_f_nxt     = lvr_f_r;
    key_f_nxt     = key_f_r;
    wake_en_nxt   = wake_en_r;
    ev_en_nxt     = ev_en_r;
    ev_st_nxt     = ev_st_r;
    cnt_nxt       = cnt_r;
    kdly_nxt      = kdly_r;
    kpend_nxt     = kpend_r;
    pwr_nxt       = pwr_r;
    irq_block_nxt = irq_block_r;
    pdf_nxt       = pdf_r;
    to_nxt        = to_r;
    sysrst_nxt    = 1'b0;
    pcsp_nxt      = 1'b0;
    resume_nxt    = 1'b0;
    svc_nxt       = 1'b0;
    ack_nxt       = wb_cyc_i && wb_stb_i && !ack_r;
    dat_nxt       = 32'h0;
    ev_set        = '0;

    // Bus writes; flags may only be cleared
    if (wr)
    begin
      unique case (wb_adr_i)
        WDW_ADR_WDT_CTRL: wdt_ctrl_nxt = wb_dat_i[7:0];
        WDW_ADR_IDLE_RST:
        begin
          sysclk_nxt = wb_dat_i[WDW_BIT_SYSCLK];
          if (!wb_dat_i[WDW_BIT_LVR])
            lvr_f_nxt = 1'b0;
          if (!wb_dat_i[WDW_BIT_KEYRST])
            key_f_nxt = 1'b0;
        end
        WDW_ADR_STATUS:
        begin
          ev_en_nxt = wb_dat_i[8 +: WDW_EV_W];
          ev_st_nxt = ev_st_r & ~wb_dat_i[16 +: WDW_EV_W];
        end
        WDW_ADR_WAKE_EN: wake_en_nxt = wb_dat_i[PORT_W-1:0];
        default: ;
      endcase
    end
    if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r)
    begin
      unique case (wb_adr_i)
        WDW_ADR_WDT_CTRL: dat_nxt[7:0] = wdt_ctrl_r;
        WDW_ADR_IDLE_RST: dat_nxt[7:0] = {sysclk_r, 4'h0, lvr_f_r, 1'b0, key_f_r};
        WDW_ADR_STATUS:
          dat_nxt = {13'h0, ev_en_r, 5'h0, ev_en_r, 5'h0, ev_st_r} & 32'h0000_0707;
        WDW_ADR_WAKE_EN: dat_nxt[PORT_W-1:0] = wake_en_r;
        default: ;
      endcase
    end

    if (lvr_event_i)
      lvr_f_nxt = 1'b1;

    // Invalid key: reset at the second slow edge, even if rewritten meanwhile
    if (key_bad && !kpend_r)
    begin
      kpend_nxt = 1'b1;
      kdly_nxt  = WDW_KEYRST_DLY - 2'h1;
    end
    else if (kpend_r && slow_tick && kdly_r != 2'h0)
      kdly_nxt = kdly_r - 2'h1;

    if (wdt_on && slow_tick)
      cnt_nxt = cnt_r + 1'b1;

    if (clear_watchdog_instruction_i)
    begin
      cnt_nxt = '0;
      pdf_nxt = 1'b0;
    end

    // Halt: enter sleep or idle, remember already-pending interrupt
    if (halt_i && !asleep)
    begin
      cnt_nxt       = '0;
      pdf_nxt       = 1'b1;
      to_nxt        = 1'b0;
      irq_block_nxt = irq_req_i;
      pwr_nxt       = idle_mode_i ? WDW_IDLE : WDW_SLEEP;
    end

    if (asleep && (wake_pin || (wake_irq && (!irq_enabled_i || stack_full_i))))
    begin
      pwr_nxt    = WDW_RUN;
      resume_nxt = 1'b1;
      ev_set[WDW_EV_WAKE] = 1'b1;
    end
    else if (wake_irq)
    begin
      pwr_nxt = WDW_RUN;
      svc_nxt = 1'b1;
      ev_set[WDW_EV_WAKE] = 1'b1;
    end
    if (!asleep && irq_block_r && !irq_req_i)
      irq_block_nxt = 1'b0;

    if (overflow)
    begin
      cnt_nxt = '0;
      to_nxt  = 1'b1;
      ev_set[WDW_EV_TIMEOUT] = 1'b1;
      if (asleep)
      begin
        pcsp_nxt = 1'b1;
        pwr_nxt  = WDW_RUN;
        ev_set[WDW_EV_WAKE] = 1'b1;
      end
      else
        sysrst_nxt = 1'b1;
    end

    if (key_fire)
    begin
      key_f_nxt    = 1'b1;
      sysrst_nxt   = 1'b1;
      cnt_nxt      = '0;
      kpend_nxt    = 1'b0;
      wdt_ctrl_nxt = WDW_WDT_CTRL_RST;
      pwr_nxt      = WDW_RUN;
      ev_set[WDW_EV_KEYRST] = 1'b1;
    end

    if (ext_rst)
    begin
      sysrst_nxt   = 1'b1;
      cnt_nxt      = '0;
      wdt_ctrl_nxt = WDW_WDT_CTRL_RST;
      kpend_nxt    = 1'b0;
      pwr_nxt      = WDW_RUN;
    end

    // Set beats a simultaneous clear
    ev_st_nxt = ev_st_nxt | ev_set;
    sclk_nxt  = (pwr_nxt == WDW_RUN) || (pwr_nxt == WDW_IDLE && sysclk_nxt);
    irq_nxt   = |(ev_st_nxt & ev_en_nxt);
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wdt_ctrl_r  <= WDW_WDT_CTRL_RST;
      sysclk_r    <= WDW_IDLE_RST_RST[WDW_BIT_SYSCLK];
      lvr_f_r     <= 1'b0;
      key_f_r     <= 1'b0;
      wake_en_r   <= '0;
      ev_st_r     <= '0;
      ev_en_r     <= '0;
      cnt_r       <= '0;
      kdly_r      <= 2'h0;
      kpend_r     <= 1'b0;
      pwr_r       <= WDW_RUN;
      irq_block_r <= 1'b0;
      pdf_r       <= 1'b0;
      to_r        <= 1'b0;
      ack_r       <= 1'b0;
      dat_r       <= 32'h0;
      sysrst_r    <= 1'b0;
      pcsp_r      <= 1'b0;
      resume_r    <= 1'b0;
      svc_r       <= 1'b0;
      sclk_r      <= 1'b1;
      irq_r       <= 1'b0;
    end
    else
    begin
      wdt_ctrl_r  <= wdt_ctrl_nxt;
      sysclk_r    <= sysclk_nxt;
      lvr_f_r     <= lvr_f_nxt;
      key_f_r     <= key_f_nxt;
      wake_en_r   <= wake_en_nxt;
      ev_st_r     <= ev_st_nxt;
      ev_en_r     <= ev_en_nxt;
      cnt_r       <= cnt_nxt;
      kdly_r      <= kdly_nxt;
      kpend_r     <= kpend_nxt;
      pwr_r       <= pwr_nxt;
      irq_block_r <= irq_block_nxt;
      pdf_r       <= pdf_nxt;
      to_r        <= to_nxt;
      ack_r       <= ack_nxt;
      dat_r       <= dat_nxt;
      sysrst_r    <= sysrst_nxt;
      pcsp_r      <= pcsp_nxt;
      resume_r    <= resume_nxt;
      svc_r       <= svc_nxt;
      sclk_r      <= sclk_nxt;
      irq_r       <= irq_nxt;
    end
  end

  assign wb_dat_o           = dat_r;
  assign wb_ack_o           = ack_r;
  assign system_reset_o     = sysrst_r;
  assign pc_sp_reset_o      = pcsp_r;
  assign wake_resume_o      = resume_r;
  assign wake_irq_service_o = svc_r;
  assign sysclk_run_o       = sclk_r;
  assign power_down_flag_o  = pdf_r;
  assign timeout_flag_o     = to_r;
  assign irq_o              = irq_r;

endmodule

// ---- verilog/wdw_pkg.sv ----
package wdw_pkg;

  // Wishbone word byte addresses
  localparam logic [3:0] WDW_ADR_WDT_CTRL  = 4'h0;
  localparam logic [3:0] WDW_ADR_IDLE_RST  = 4'h4;
  localparam logic [3:0] WDW_ADR_STATUS    = 4'h8;
  localparam logic [3:0] WDW_ADR_WAKE_EN   = 4'hC;

  localparam logic [7:0] WDW_WDT_CTRL_RST  = 8'h53;
  localparam int         WDW_KEY_MSB       = 7;
  localparam int         WDW_KEY_LSB       = 3;
  localparam int         WDW_PER_MSB       = 2;
  localparam logic [4:0] WDW_KEY_DISABLE   = 5'h15;
  localparam logic [4:0] WDW_KEY_ENABLE    = 5'h0A;

  localparam int         WDW_BIT_SYSCLK    = 7;
  localparam int         WDW_BIT_LVR       = 2;
  localparam int         WDW_BIT_KEYRST    = 0;
  localparam logic [7:0] WDW_IDLE_RST_RST  = 8'h00;

  // Event status / enable / clear layout (offset +0 status, +1 enable, +2 clear in byte lanes)
  localparam int         WDW_EV_TIMEOUT    = 0;
  localparam int         WDW_EV_KEYRST     = 1;
  localparam int         WDW_EV_WAKE       = 2;
  localparam int         WDW_EV_W          = 3;

  localparam int         WDW_BASE_EXP      = 8;
  localparam int         WDW_CNT_W         = 16;
  // Reset request delay in slow-oscillator cycles (1 to 2 from the key write)
  localparam logic [1:0] WDW_KEYRST_DLY    = 2'h2;

  typedef enum logic [1:0]
  {
    WDW_RUN   = 2'b00,
    WDW_SLEEP = 2'b01,
    WDW_IDLE  = 2'b10
  } wdw_pwr_e;

endpackage

// ---- sim/wdw_top_monitor.sv ----
`timescale 1ns/10ps
module wdw_chk
  import wdw_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        arst_n_i,
  input wire logic        ext_reset_i,
  input wire logic        halt_i,
  input wire logic        clear_watchdog_instruction_i,
  input wire logic        irq_enabled_i,
  input wire logic        stack_full_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        pc_sp_reset_o,
  input wire logic        wake_resume_o,
  input wire logic        wake_irq_service_o,
  input wire logic        sysclk_run_o,
  input wire logic        power_down_flag_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_wake;
    wake_resume_o || wake_irq_service_o || pc_sp_reset_o;
  endsequence
  AST_ACK_NEXT: assert property (s_take |=> wb_ack_o) else $error("ack missing");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_RD_HIGH: assert property
    (wb_ack_o && !$past(wb_we_i) |-> wb_dat_o[31:11] == 21'h0) else $error("upper bits set");
  AST_PDF_SET: assert property
    (halt_i && !clear_watchdog_instruction_i && !ext_reset_i |=> power_down_flag_o)
    else $error("halt left pdf low");
  AST_PDF_CLR: assert property
    (clear_watchdog_instruction_i && !halt_i |=> !power_down_flag_o) else $error("pdf kept");
  AST_WAKE_SLEPT: assert property (s_wake |-> $past(power_down_flag_o))
    else $error("wake while running");
  AST_SVC_COND: assert property
    (wake_irq_service_o |-> $past(irq_enabled_i) && !$past(stack_full_i))
    else $error("service wrongly taken");
  AST_WAKE_EXCL: assert property
    (wake_resume_o |-> !wake_irq_service_o && !pc_sp_reset_o) else $error("two wake kinds");
  AST_CLK_IDLE: assert property (!sysclk_run_o |-> power_down_flag_o)
    else $error("clock stopped while running");
endmodule
bind wdw_top wdw_chk u_chk (.clock_i, .arst_n_i, .ext_reset_i, .halt_i,
  .clear_watchdog_instruction_i, .irq_enabled_i, .stack_full_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_ack_o, .wb_dat_o, .pc_sp_reset_o, .wake_resume_o, .wake_irq_service_o,
  .sysclk_run_o, .power_down_flag_o);

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module testbench
  import wdw_pkg::*;
;
  logic clock_i, arst_n_i, ext_i, lvr, halt, idle, clr, ireq, ien, sfull;
  logic        sosc = 1'b0;
  logic cyc, stb, we, ack, rst, psr, res, svc, sclk, power_down_flag, tof, irq;
  logic [7:0]  port_a;
  logic [3:0]  adr;
  logic [31:0] wdat, rdat, q;
  int          err_count, n_tests, n_rst, n_psr, n_res, n_svc, sdiv, b;
  wdw_top #(.PORT_W(8)) dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .ext_reset_i(ext_i),
    .lvr_event_i(lvr), .slow_osc_i(sosc), .port_a_i(port_a), .halt_i(halt),
    .idle_mode_i(idle), .clear_watchdog_instruction_i(clr), .irq_req_i(ireq),
    .irq_enabled_i(ien), .stack_full_i(sfull), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(q), .wb_ack_o(ack),
    .system_reset_o(rst), .pc_sp_reset_o(psr), .wake_resume_o(res),
    .wake_irq_service_o(svc), .sysclk_run_o(sclk), .power_down_flag_o(power_down_flag),
    .timeout_flag_o(tof), .irq_o(irq));
  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // Slow oscillator at one sixth of the clock keeps overflow runs near 1.5k cycles
  always @(posedge clock_i)
  begin
    sdiv <= (sdiv == 2) ? 0 : sdiv + 1;
    if (sdiv == 2)
      sosc <= ~sosc;
    n_rst <= n_rst + rst;
    n_psr <= n_psr + psr;
    n_res <= n_res + res;
    n_svc <= n_svc + svc;
  end
  task automatic report_and_stop;
    if (err_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clock_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clock_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = q;
    `CHK("ack", 1'b1, ack)
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK("rdata", e, rdat)
  endtask
  // Kind 0 halt, 1 clear watchdog, 2 low-voltage event
  task automatic pulse(input int k, input logic m);
    @(posedge clock_i);
    halt <= (k == 0);
    idle <= m;
    clr <= (k == 1);
    lvr <= (k == 2);
    @(posedge clock_i);
    {halt, clr, lvr} <= 3'h0;
  endtask
  initial
  begin
    {arst_n_i, ext_i, lvr, halt, idle, clr, ireq, ien, sfull, cyc, stb, we} = 12'h0;
    port_a = 8'hFF;
    adr = 4'h0;
    wdat = 32'h0;
    step(10);
    arst_n_i <= 1'b1;
    rd(WDW_ADR_WDT_CTRL, 32'h53);
    `CHK("pdf_por", 1'b0, power_down_flag)
    `CHK("to_por", 1'b0, tof)
    wb(1'b1, 4'h2, 32'hFF);
    rd(4'h2, 32'h0);
    rd(WDW_ADR_IDLE_RST, 32'h0);
    rd(WDW_ADR_WAKE_EN, 32'h0);
    wb(1'b1, WDW_ADR_IDLE_RST, 32'hFF);
    rd(WDW_ADR_IDLE_RST, 32'h80);
    pulse(2, 1'b0);
    rd(WDW_ADR_IDLE_RST, 32'h84);
    wb(1'b1, WDW_ADR_IDLE_RST, 32'h80);
    wb(1'b1, WDW_ADR_IDLE_RST, 32'h84);
    rd(WDW_ADR_IDLE_RST, 32'h80);
    wb(1'b1, WDW_ADR_WAKE_EN, 32'h01);
    pulse(0, 1'b1);
    step(2);
    `CHK("pdf", 1'b1, power_down_flag)
    `CHK("sysclk", 1'b1, sclk)
    port_a <= 8'hFD;
    step(10);
    `CHK("pin_off", 0, n_res)
    port_a <= 8'hFC;
    step(10);
    `CHK("pin_wake", 1, n_res)
    port_a <= 8'hFF;
    pulse(1, 1'b0);
    step(2);
    `CHK("pdf_clr", 1'b0, power_down_flag)
    rd(WDW_ADR_STATUS, 32'h4);
    `CHK("irq_mask", 1'b0, irq)
    wb(1'b1, WDW_ADR_STATUS, 32'h400);
    step(2);
    `CHK("irq_on", 1'b1, irq)
    wb(1'b1, WDW_ADR_STATUS, 32'h40400);
    step(2);
    `CHK("irq_clr", 1'b0, irq)
    rd(WDW_ADR_STATUS, 32'h400);
    wb(1'b1, WDW_ADR_STATUS, 32'h0);
    wb(1'b1, WDW_ADR_IDLE_RST, 32'h0);
    pulse(0, 1'b1);
    step(2);
    `CHK("sysclk_off", 1'b0, sclk)
    ien <= 1'b1;
    ireq <= 1'b1;
    step(4);
    `CHK("irq_svc", 1, n_svc)
    {ireq, ien} <= 2'b00;
    pulse(0, 1'b0);
    ireq <= 1'b1;
    step(4);
    `CHK("irq_resume", 2, n_res)
    pulse(0, 1'b0);
    step(10);
    `CHK("pend_nowake", 2, n_res + n_svc - 1)
    ireq <= 1'b0;
    ext_i <= 1'b1;
    step(4);
    ext_i <= 1'b0;
    step(6);
    `CHK("ext_wake", 1'b1, n_rst > 0)
    b = n_rst;
    wb(1'b1, WDW_ADR_WDT_CTRL, 32'h50);
    pulse(1, 1'b0);
    pulse(0, 1'b0);
    step(1500);
    `CHK("sleep_early", 0, n_psr)
    step(150);
    `CHK("sleep_ovf", 1, n_psr)
    `CHK("to_flag", 1'b1, tof)
    `CHK("pdf_kept", 1'b1, power_down_flag)
    `CHK("no_full_rst", b, n_rst)
    pulse(1, 1'b0);
    step(1500);
    `CHK("run_early", b, n_rst)
    step(150);
    `CHK("run_ovf", b + 1, n_rst)
    rd(WDW_ADR_IDLE_RST, 32'h00);
    wb(1'b1, WDW_ADR_WDT_CTRL, 32'hA8);
    pulse(1, 1'b0);
    step(1700);
    `CHK("disabled", b + 1, n_rst)
    wb(1'b1, WDW_ADR_WDT_CTRL, 32'h00);
    step(6);
    `CHK("key_early", b + 1, n_rst)
    step(10);
    `CHK("key_rst", b + 2, n_rst)
    rd(WDW_ADR_WDT_CTRL, 32'h53);
    rd(WDW_ADR_STATUS, 32'h7);
    rd(WDW_ADR_IDLE_RST, 32'h01);
    wb(1'b1, WDW_ADR_IDLE_RST, 32'h01);
    rd(WDW_ADR_IDLE_RST, 32'h01);
    wb(1'b1, WDW_ADR_IDLE_RST, 32'h00);
    rd(WDW_ADR_IDLE_RST, 32'h00);
    report_and_stop();
  end
  initial
  begin
    step(20000);
    err_count++;
    report_and_stop();
  end
endmodule
